// ---- include/lfd_pkg.sv ----
// Constants, field layouts and types for the frame-fetch display controller
package lfd_pkg;
   localparam int PWR_EN_BIT   = 0;
   localparam int FETCH_EN_BIT = 0;
   localparam int BYPASS_BIT   = 0;
   localparam int DUAL_BIT     = 1;
   localparam int DIV_LSB      = 12;
   localparam int DIV_W        = 9;
   localparam int CNT_W        = 11;
   localparam int HSIZE_LSB    = 21;
   localparam int LINES_LSB    = 0;
   localparam int VFRONT_LSB   = 0;
   localparam int VFRONT_W     = 8;
   localparam int VBACK_LSB    = 8;
   localparam int VBACK_W      = 8;
   localparam int VPULSE_LSB   = 16;
   localparam int VPULSE_W     = 6;
   localparam int VHD_LSB      = 24;
   localparam int VHD_W        = 8;
   localparam int HBACK_LSB    = 0;
   localparam int HBACK_W      = 8;
   localparam int HPULSE_LSB   = 8;
   localparam int HPULSE_W     = 6;
   localparam int HFRONT_LSB   = 21;
   localparam int FSIZE_LSB    = 0;
   localparam int FSIZE_W      = 23;
   localparam int BURST_LSB    = 24;
   localparam int BURST_W      = 7;
   localparam int DITHER_N     = 8;
   localparam int DITHER_W     = 28;
   localparam logic [31:0] ADDR_STEP = 32'h4;
   localparam logic [1:0] PH_PULSE  = 2'h0;
   localparam logic [1:0] PH_BACK   = 2'h1;
   localparam logic [1:0] PH_ACTIVE = 2'h2;
   localparam logic [1:0] PH_FRONT  = 2'h3;
   // Entry 7 is listed first, entry 0 last
   localparam logic [DITHER_N-1:0][DITHER_W-1:0] DITHER_RESET = {
      28'hf5ffaff, 28'h00faf5f, 28'h000faf5, 28'hfaf5fa5,
      28'h0000a5f, 28'h00a5a5f, 28'h5af0fa5, 28'h00000a5};
   typedef enum logic [1:0] {CORE_IDLE, CORE_ACTIVE, CORE_DRAIN} lfd_core_state_t;
endpackage : lfd_pkg

// ---- rtl/lfd_pixclk_div.sv ----
// Pixel clock divider with bypass, producing a pin level and a tick on its rising edge, or every cycle in bypass
module lfd_pixclk_div #(
   parameter int DW = lfd_pkg::DIV_W
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          run,
   input  wire logic          bypass,
   input  wire logic [DW-1:0] divisor,
   output logic               pixelClock,
   output logic               pixelTick
);
   import lfd_pkg::*;

   typedef struct packed {
      logic [DW-1:0] cnt;
      logic          pclk;
      logic          tick;
   } lfd_div_t;

   lfd_div_t q, d;
   logic [DW-1:0] half;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      // Zero divisor would stall the clock, so treat it as one
      half = (divisor == '0) ? DW'(1) : divisor;
      if (!run) begin
         d.cnt = '0;
         d.pclk = 1'b0;
      end else if (bypass) begin
         d.cnt = '0;
         d.pclk = ~q.pclk;
         d.tick = 1'b1;
      end else if (q.cnt == half - DW'(1)) begin
         d.cnt = '0;
         d.pclk = ~q.pclk;
         d.tick = ~q.pclk;
      end else begin
         d.cnt = q.cnt + DW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pixelClock = q.pclk;
   assign pixelTick  = q.tick;

   a_bypass_tick: assert property (@(posedge clk) disable iff (sys_rst)
      run && bypass |=> pixelTick)
      else $error("bypass did not tick every cycle");
endmodule : lfd_pixclk_div

// ---- rtl/lfd_display_ctrl.sv ----
// Display core timing, activation control and frame-fetch engine with double buffering
module lfd_display_ctrl (
   input  wire logic                                       clk,
   input  wire logic                                       sys_rst,
   input  wire logic [31:0]                                powerControlReg,
   input  wire logic [31:0]                                fetchControlReg,
   input  wire logic [31:0]                                controlRegOne,
   input  wire logic [31:0]                                controlRegTwo,
   input  wire logic [31:0]                                verticalTimingReg,
   input  wire logic [31:0]                                horizontalTimingReg,
   input  wire logic [31:0]                                panelSizeReg,
   input  wire logic [31:0]                                fetchFrameCfg,
   input  wire logic [31:0]                                upperBaseAddr,
   input  wire logic [31:0]                                lowerBaseAddr,
   input  wire logic                                       ditherWrite,
   input  wire logic [2:0]                                 ditherIndex,
   input  wire logic [lfd_pkg::DITHER_W-1:0]               ditherData,
   input  wire logic                                       fetchAck,
   input  wire logic [31:0]                                fetchData,
   output logic                                            coreBusy,
   output logic                                            pixelClock,
   output logic                                            hsyncOut,
   output logic                                            vsyncOut,
   output logic                                            dataEnable,
   output logic                                            fetchReq,
   output logic [31:0]                                     fetchAddr,
   output logic [lfd_pkg::BURST_W-1:0]                     fetchBurst,
   output logic [lfd_pkg::FSIZE_W-1:0]                     remainingWordsUpper,
   output logic [lfd_pkg::FSIZE_W-1:0]                     remainingWordsLower,
   output logic                                            endOfFrame,
   output logic [31:0]                                     pixelWord,
   output logic                                            pixelWordValid,
   output logic                                            pixelWordLower,
   output logic [lfd_pkg::DITHER_N*lfd_pkg::DITHER_W-1:0]  ditherPatterns
);
   import lfd_pkg::*;

   typedef struct packed {
      lfd_core_state_t                  st;
      logic [1:0]                       hPh;
      logic [CNT_W-1:0]                 hCnt;
      logic [1:0]                       vPh;
      logic [CNT_W-1:0]                 vCnt;
      logic                             hsync;
      logic                             vsync;
      logic                             de;
      logic                             fetching;
      logic                             sel;
      logic [31:0]                      curUp;
      logic [31:0]                      curLo;
      logic [FSIZE_W-1:0]               remUp;
      logic [FSIZE_W-1:0]               remLo;
      logic                             eof;
      logic [31:0]                      word;
      logic                             wordVal;
      logic                             wordLower;
      logic [DITHER_N-1:0][DITHER_W-1:0] dith;
   } lfd_state_t;

   lfd_state_t q, d;

   logic                coreEnable;
   logic                fetchEnable;
   logic                dualScan;
   logic                pixTick;
   logic                fetchRun;
   logic                selEff;
   logic                lineEnd;
   logic                frameEnd;
   logic [CNT_W-1:0]    hLen;
   logic [CNT_W-1:0]    vLen;
   logic [CNT_W-1:0]    hPulseLen;
   logic [CNT_W-1:0]    vhd;
   logic [FSIZE_W-1:0]  frameWords;

   assign coreEnable  = powerControlReg[PWR_EN_BIT];
   assign fetchEnable = fetchControlReg[FETCH_EN_BIT];
   assign dualScan    = controlRegTwo[DUAL_BIT];
   assign frameWords  = fetchFrameCfg[FSIZE_LSB +: FSIZE_W];
   assign fetchRun    = (q.st == CORE_ACTIVE) && fetchEnable;
   assign hPulseLen = CNT_W'(horizontalTimingReg[HPULSE_LSB +: HPULSE_W]);
   assign vhd = CNT_W'(verticalTimingReg[VHD_LSB +: VHD_W]);

   lfd_pixclk_div #(
      .DW (DIV_W)
   ) u_div (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .run        (q.st != CORE_IDLE),
      .bypass     (controlRegOne[BYPASS_BIT]),
      .divisor    (controlRegOne[DIV_LSB +: DIV_W]),
      .pixelClock (pixelClock),
      .pixelTick  (pixTick)
   );

   // Phase lengths are stored as count minus one
   always_comb begin
      case (q.hPh)
         PH_PULSE:  hLen = hPulseLen;
         PH_BACK:   hLen = CNT_W'(horizontalTimingReg[HBACK_LSB +: HBACK_W]);
         PH_ACTIVE: hLen = panelSizeReg[HSIZE_LSB +: CNT_W];
         default:   hLen = horizontalTimingReg[HFRONT_LSB +: CNT_W];
      endcase
      case (q.vPh)
         PH_PULSE:  vLen = CNT_W'(verticalTimingReg[VPULSE_LSB +: VPULSE_W]);
         PH_BACK:   vLen = CNT_W'(verticalTimingReg[VBACK_LSB +: VBACK_W]);
         PH_ACTIVE: vLen = panelSizeReg[LINES_LSB +: CNT_W];
         default:   vLen = CNT_W'(verticalTimingReg[VFRONT_LSB +: VFRONT_W]);
      endcase
   end

   assign lineEnd  = pixTick && (q.hPh == PH_FRONT) && (q.hCnt == hLen);
   assign frameEnd = lineEnd && (q.vPh == PH_FRONT) && (q.vCnt == vLen);
   // Dual scan interleaves panels; an exhausted panel yields to the other
   assign selEff = !dualScan ? 1'b0 : (q.remUp == '0) ? 1'b1 :
                   (q.remLo == '0) ? 1'b0 : q.sel;
   // Gating by the run condition drops the request the cycle the core stops
   assign fetchReq = q.fetching && fetchRun
                     && (selEff ? (q.remLo != '0) : (q.remUp != '0));

   always_comb begin
      d = q;
      d.eof = 1'b0;
      d.wordVal = 1'b0;
      case (q.st)
         CORE_IDLE: begin
            if (coreEnable) begin
               d.st = CORE_ACTIVE;
            end
         end
         CORE_ACTIVE: begin
            if (!coreEnable) begin
               d.st = CORE_DRAIN;
            end
         end
         CORE_DRAIN: begin
            // Finish the frame so the panel never sees a cut-off frame
            if (frameEnd) begin
               d.st = CORE_IDLE;
            end
         end
         default: d.st = CORE_IDLE;
      endcase
      if (q.st == CORE_IDLE) begin
         d.hPh = PH_PULSE;
         d.hCnt = '0;
         d.vPh = PH_PULSE;
         d.vCnt = '0;
         d.hsync = 1'b0;
         d.vsync = 1'b0;
         d.de = 1'b0;
      end else if (pixTick) begin
         if (q.hCnt == hLen) begin
            d.hCnt = '0;
            d.hPh = q.hPh + 2'h1;
         end else begin
            d.hCnt = q.hCnt + CNT_W'(1);
         end
         if (lineEnd) begin
            if (q.vCnt == vLen) begin
               d.vCnt = '0;
               d.vPh = q.vPh + 2'h1;
            end else begin
               d.vCnt = q.vCnt + CNT_W'(1);
            end
         end
         d.hsync = (d.hPh == PH_PULSE);
         // Vertical sync moves a set delay into the line pulse, capped at its end
         if (q.hPh == PH_PULSE && (q.hCnt == vhd || q.hCnt == hPulseLen)) begin
            d.vsync = (q.vPh == PH_PULSE);
         end
         d.de = (d.hPh == PH_ACTIVE) && (d.vPh == PH_ACTIVE);
      end
      if (!fetchRun) begin
         d.fetching = 1'b0;
      end else if (!q.fetching || (q.remUp == '0 && q.remLo == '0)) begin
         // Shadow copies give double buffering: base ports are read only here
         d.fetching = 1'b1;
         d.curUp = upperBaseAddr;
         d.curLo = lowerBaseAddr;
         d.remUp = frameWords;
         d.remLo = dualScan ? frameWords : '0;
         d.sel = 1'b0;
         d.eof = 1'b1;
      end else if (fetchReq && fetchAck) begin
         d.word = fetchData;
         d.wordVal = 1'b1;
         d.wordLower = selEff;
         d.sel = ~selEff;
         if (selEff) begin
            d.remLo = q.remLo - FSIZE_W'(1);
            d.curLo = q.curLo + ADDR_STEP;
         end else begin
            d.remUp = q.remUp - FSIZE_W'(1);
            d.curUp = q.curUp + ADDR_STEP;
         end
      end
      if (ditherWrite) begin
         d.dith[ditherIndex] = ditherData;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
         q.st <= CORE_IDLE;
         q.dith <= DITHER_RESET;
      end else begin
         q <= d;
      end
   end

   assign coreBusy            = (q.st != CORE_IDLE);
   assign hsyncOut            = q.hsync;
   assign vsyncOut            = q.vsync;
   assign dataEnable          = q.de;
   assign fetchAddr           = selEff ? q.curLo : q.curUp;
   assign fetchBurst          = fetchFrameCfg[BURST_LSB +: BURST_W];
   assign remainingWordsUpper = q.remUp;
   assign remainingWordsLower = q.remLo;
   assign endOfFrame          = q.eof;
   assign pixelWord           = q.word;
   assign pixelWordValid      = q.wordVal;
   assign pixelWordLower      = q.wordLower;
   assign ditherPatterns      = q.dith;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_fetch_needs_core: assert property (fetchReq |-> coreBusy && !(q.st == CORE_DRAIN)
      && fetchEnable)
      else $error("fetch requested without active core");
   a_fetch_enable_gate: assert property (!fetchEnable |=> !fetchReq)
      else $error("fetch ran with fetch enable clear");
   a_busy_held: assert property (q.st == CORE_ACTIVE && !coreEnable |=> coreBusy
      && q.st == CORE_DRAIN && !fetchReq)
      else $error("busy dropped or fetch kept running at shutdown");
   a_drain_hold: assert property (q.st == CORE_DRAIN && !frameEnd |=> coreBusy)
      else $error("busy dropped before frame finished");
   a_reload_eof: assert property (endOfFrame |-> remainingWordsUpper == $past(frameWords)
      && q.curUp == $past(upperBaseAddr))
      else $error("end of frame without pointer reload");
   a_single_upper: assert property (fetchReq && !dualScan |-> fetchAddr == q.curUp
      && remainingWordsLower == '0)
      else $error("single scan used lower panel");
   a_ptr_down: assert property (fetchReq && fetchAck && !selEff && !endOfFrame && fetchRun
      |=> remainingWordsUpper == $past(remainingWordsUpper) - FSIZE_W'(1))
      else $error("upper pointer did not count down");
   a_base_shadow: assert property ($changed(q.curUp) |-> endOfFrame
      || q.curUp == $past(q.curUp) + ADDR_STEP)
      else $error("base address took effect mid frame");
   a_dither_reset: assert property (disable iff (1'b0) sys_rst |=> ditherPatterns
      == DITHER_RESET)
      else $error("dither defaults not loaded");
   a_de_not_sync: assert property (dataEnable |-> !hsyncOut)
      else $error("data enable overlaps line pulse");

   c_frame_reload: cover property (endOfFrame ##1 !endOfFrame [*2] ##1 pixelWordValid);
   c_lower_word: cover property (pixelWordValid && pixelWordLower);
   c_drain_idle: cover property (q.st == CORE_DRAIN ##1 q.st == CORE_IDLE);
endmodule : lfd_display_ctrl

// ---- test/lfd_mem_model.sv ----
// Image memory model answering frame-fetch requests, prompt or slow
module lfd_mem_model (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        slow,
   input  wire logic        fetchReq,
   input  wire logic [31:0] fetchAddr,
   output logic             fetchAck,
   output logic [31:0]      fetchData
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] MIX = 32'h3c3c0000;
   logic [1:0] gap = 2'h0;
   // Idle data is inverted each cycle so a stale word never passes as fresh
   always @(negedge clk) begin
      if (sys_rst) begin
         fetchAck  <= 1'b0;
         fetchData <= 32'h0;
         gap       <= 2'h0;
      end else begin
         gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
         if (fetchReq && (!slow || gap == 2'h0)) begin
            fetchAck  <= 1'b1;
            fetchData <= fetchAddr ^ MIX;
         end else begin
            fetchAck  <= 1'b0;
            fetchData <= ~fetchData;
         end
      end
   end
endmodule : lfd_mem_model

// ---- test/lfd_display_ctrl_bench.sv ----
// Self-checking bench for the display controller bring-up and frame fetch
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module lfd_display_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lfd_pkg::*;
   localparam logic [31:0] MIX = 32'h3c3c0000;
   logic clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, ditherWrite = 1'b0;
   logic [31:0] powerControlReg = 32'h0, fetchControlReg = 32'h0, controlRegOne = 32'h0;
   logic [31:0] controlRegTwo = 32'h0, verticalTimingReg = 32'h0, horizontalTimingReg = 32'h0;
   logic [31:0] panelSizeReg = 32'h0, fetchFrameCfg = 32'h0;
   logic [31:0] upperBaseAddr = 32'h0, lowerBaseAddr = 32'h0;
   logic [2:0] ditherIndex = 3'h0;
   logic [DITHER_W-1:0] ditherData = 28'h0;
   logic fetchAck, coreBusy, pixelClock, hsyncOut, vsyncOut, dataEnable, fetchReq;
   logic endOfFrame, pixelWordValid, pixelWordLower;
   logic [31:0] fetchData, fetchAddr, pixelWord;
   logic [BURST_W-1:0] fetchBurst;
   logic [FSIZE_W-1:0] remainingWordsUpper, remainingWordsLower;
   logic [DITHER_N*DITHER_W-1:0] ditherPatterns;
   int n_fail = 0, tests_run = 0, w;

   always #10 clk = ~clk;

   lfd_display_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .powerControlReg(powerControlReg),
      .fetchControlReg(fetchControlReg), .controlRegOne(controlRegOne),
      .controlRegTwo(controlRegTwo), .verticalTimingReg(verticalTimingReg),
      .horizontalTimingReg(horizontalTimingReg), .panelSizeReg(panelSizeReg),
      .fetchFrameCfg(fetchFrameCfg), .upperBaseAddr(upperBaseAddr),
      .lowerBaseAddr(lowerBaseAddr), .ditherWrite(ditherWrite), .ditherIndex(ditherIndex),
      .ditherData(ditherData), .fetchAck(fetchAck), .fetchData(fetchData),
      .coreBusy(coreBusy), .pixelClock(pixelClock), .hsyncOut(hsyncOut),
      .vsyncOut(vsyncOut), .dataEnable(dataEnable), .fetchReq(fetchReq),
      .fetchAddr(fetchAddr), .fetchBurst(fetchBurst),
      .remainingWordsUpper(remainingWordsUpper), .remainingWordsLower(remainingWordsLower),
      .endOfFrame(endOfFrame), .pixelWord(pixelWord), .pixelWordValid(pixelWordValid),
      .pixelWordLower(pixelWordLower), .ditherPatterns(ditherPatterns));

   lfd_mem_model mem (.clk(clk), .sys_rst(sys_rst), .slow(slow), .fetchReq(fetchReq),
      .fetchAddr(fetchAddr), .fetchAck(fetchAck), .fetchData(fetchData));

   task finish_test;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task step_bound(inout int n);
      @(negedge clk);
      n++;
      if (n > 3000) begin
         n_fail++;
         $display("mismatch at %0t: wait ran out", $time);
         finish_test();
      end
   endtask : step_bound

   function automatic logic pick(input int which);
      case (which)
         0: pick = hsyncOut;
         1: pick = vsyncOut;
         2: pick = dataEnable;
         default: pick = pixelClock;
      endcase
   endfunction : pick

   // High time in core clocks of the next full pulse
   task measure(input int which, output int width);
      int n;
      n = 0;
      while (pick(which) !== 1'b0) step_bound(n);
      while (pick(which) !== 1'b1) step_bound(n);
      width = 0;
      while (pick(which) === 1'b1) begin
         step_bound(n);
         width++;
      end
   endtask : measure

   task wait_eof;
      int n;
      n = 0;
      step_bound(n);
      while (endOfFrame !== 1'b1) step_bound(n);
   endtask : wait_eof

   task take_word(input logic [31:0] addr, input logic low, input logic [22:0] rem);
      int n;
      n = 0;
      step_bound(n);
      while (pixelWordValid !== 1'b1) step_bound(n);
      `CHK(pixelWord, addr ^ MIX);
      `CHK(pixelWordLower, low);
      `CHK(low ? remainingWordsLower : remainingWordsUpper, rem);
   endtask : take_word

   task t_reset;
      `CHK(ditherPatterns, {28'hf5ffaff, 28'h00faf5f, 28'h000faf5, 28'hfaf5fa5, 28'h0000a5f,
         28'h00a5a5f, 28'h5af0fa5, 28'h00000a5});
      `CHK(coreBusy, 1'b0);
      ditherWrite = 1'b1;
      ditherIndex = 3'h3;
      ditherData = 28'h1234567;
      @(negedge clk);
      ditherWrite = 1'b0;
      @(negedge clk);
      `CHK(ditherPatterns[3*DITHER_W +: DITHER_W], 28'h1234567);
      `CHK(ditherPatterns[2*DITHER_W +: DITHER_W], 28'h00a5a5f);
   endtask : t_reset

   task t_gate;
      logic seen;
      seen = 1'b0;
      // Divisor 2, 4x2 panel, STN-style zero delay fields
      controlRegOne = 32'h00002000;
      verticalTimingReg = 32'h00010000;
      horizontalTimingReg = 32'h00200201;
      panelSizeReg = 32'h00600001;
      // 4 px by 2 lines at 24 bits is 6 words, 4-word burst code
      fetchFrameCfg = 32'h07000006;
      upperBaseAddr = 32'h00001000;
      fetchControlReg = 32'h1;
      repeat (20) begin
         @(negedge clk);
         seen = seen | fetchReq;
      end
      `CHK(seen, 1'b0);
   endtask : t_gate

   task t_single;
      powerControlReg = 32'h1;
      @(negedge clk);
      `CHK(coreBusy, 1'b1);
      wait_eof();
      `CHK(remainingWordsUpper, 23'd6);
      `CHK(remainingWordsLower, 23'd0);
      `CHK(fetchBurst, 7'h07);
      take_word(32'h1000, 1'b0, 23'd5);
      take_word(32'h1004, 1'b0, 23'd4);
      upperBaseAddr = 32'h00008000;
      for (int k = 2; k < 6; k++)
         take_word(32'h1000 + 4 * k, 1'b0, 23'(5 - k));
      wait_eof();
      take_word(32'h8000, 1'b0, 23'd5);
      measure(0, w);
      `CHK(w, 12);
      measure(1, w);
      `CHK(w, 88);
      measure(2, w);
      `CHK(w, 16);
      measure(3, w);
      `CHK(w, 2);
   endtask : t_single

   task t_shutdown;
      int n;
      n = 0;
      powerControlReg = 32'h0;
      @(negedge clk);
      `CHK(fetchReq, 1'b0);
      `CHK(coreBusy, 1'b1);
      while (coreBusy !== 1'b0) step_bound(n);
      `CHK(coreBusy, 1'b0);
      fetchControlReg = 32'h0;
   endtask : t_shutdown

   task t_dual;
      controlRegTwo = 32'h2;
      controlRegOne = 32'h00000001;
      fetchFrameCfg = 32'h07000003;
      upperBaseAddr = 32'h00002000;
      lowerBaseAddr = 32'h00003000;
      slow = 1'b1;
      fetchControlReg = 32'h1;
      @(negedge clk);
      powerControlReg = 32'h1;
      wait_eof();
      `CHK(remainingWordsLower, 23'd3);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) begin
            upperBaseAddr = 32'h00004000;
            lowerBaseAddr = 32'h00005000;
         end
         take_word(32'h2000 + 4 * k, 1'b0, 23'(2 - k));
         take_word(32'h3000 + 4 * k, 1'b1, 23'(2 - k));
      end
      wait_eof();
      take_word(32'h4000, 1'b0, 23'd2);
      take_word(32'h5000, 1'b1, 23'd2);
      measure(3, w);
      `CHK(w, 1);
   endtask : t_dual

   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_gate();
      t_single();
      t_shutdown();
      t_dual();
      finish_test();
   end
endmodule : lfd_display_ctrl_bench
